// File: src/olds_pkg.sv
// Package with constants and carrier types for the open-load and supply-loss logic.
package olds_pkg;

  // Number of switched outputs.
  localparam int OUTPUTS = 4;
  // Duty code that means the output runs fully on.
  localparam logic [7:0] FULL_DUTY = 8'hff;
  // Clock rate in kHz (250 MHz).
  localparam int CLOCK_KHZ = 250000;
  // LED open-load check period in microseconds.
  localparam int LED_PERIOD_US = 100;
  // LED check period in clock cycles, rounded down as a longest time.
  localparam int LED_PERIOD_CYCLES = (LED_PERIOD_US * CLOCK_KHZ) / 1000;
  // Width of the LED period timer.
  localparam int TIMER_WIDTH = 16;
  // Number of asynchronous inputs that pass the synchroniser.
  localparam int ASYNC_WIDTH = 24;
  // Positions of the asynchronous input groups in the synchroniser vector.
  localparam int POS_BULB_LOW = 0;
  localparam int POS_LED_LOW = 4;
  localparam int POS_OVERLOAD = 8;
  localparam int POS_DIRECT = 12;
  localparam int POS_TEMP_HOT = 16;
  localparam int POS_CLAMP = 17;
  localparam int POS_GND_LOST = 18;
  localparam int POS_VDD_PRESENT = 19;
  localparam int POS_VDD_LOW = 20;
  localparam int POS_VPWR_OK = 21;
  localparam int POS_VPWR_POR = 22;
  localparam int POS_RESET_PIN = 23;
  // Reset value of the synchroniser chain (supplies taken as present).
  localparam logic [ASYNC_WIDTH-1:0] ASYNC_RESET = 24'ha80000;

  // Configuration held for the host; all-zero is the documented default.
  typedef struct packed {
    logic vdd_fail_enable;       // Logic-supply-fail detection enable.
    logic pwm_enable;            // PWM module enable.
    logic temp_feedback_enable;  // Route temperature to sense output.
    logic current_sense_enable;  // Route current recopy to sense output.
    logic [1:0] sense_output_select;  // Output whose current is copied.
    logic [3:0] sense_ratio_select;   // Per-output sense ratio.
    logic [3:0] led_load_select;      // Per-output LED threshold select.
    logic [3:0] on_openload_disable;  // Per-output on-state detection off.
    logic [3:0] output_on;            // Per-output on command.
    logic [31:0] duty_code;           // Four 8-bit duty codes, output 0 lowest.
  } olds_config_type;

  // Reset value of the configuration.
  localparam olds_config_type CONFIG_RESET = '0;

  // Sense output routing.
  typedef struct packed {
    logic temp_route;     // Temperature voltage on the sense output.
    logic current_route;  // Current recopy delivering now.
    logic [1:0] channel;  // Selected output.
    logic high_ratio;     // Ratio select of the selected output.
  } olds_sense_type;

endpackage

// File: src/olds_core.sv
// Open-load diagnosis, sense routing and supply-loss control for four outputs.
`timescale 1ns/1ns
module olds_core #(
  parameter int LED_PERIOD = olds_pkg::LED_PERIOD_CYCLES  // LED check period in cycles.
) (
  input wire logic clk,  // Device clock, 250 MHz.
  input wire logic reset_n,  // Asynchronous reset, active low.
  input wire logic config_write,  // Pulse: load config_data.
  input wire olds_pkg::olds_config_type config_data,  // Configuration from the host.
  input wire logic [3:0] status_read,  // Pulse per output: on-state status read.
  input wire logic diag_read,  // Pulse: diagnostic register 0 read.
  input wire logic fail_safe_mode,  // Level: device in fail-safe mode.
  input wire logic [3:0] bulb_low,  // Pin: current below bulb threshold.
  input wire logic [3:0] led_low,  // Pin: current below LED threshold.
  input wire logic [3:0] overload_off,  // Pin: overload turn-off in progress.
  input wire logic [3:0] direct_in,  // Pin: direct input per output.
  input wire logic temp_hot,  // Pin: ground flag above prewarning.
  input wire logic clamp_high,  // Pin: supply above clamp threshold.
  input wire logic ground_lost,  // Pin: device ground disconnected.
  input wire logic vdd_present,  // Pin: logic supply present.
  input wire logic vdd_low,  // Pin: logic supply below fail level.
  input wire logic vpwr_ok,  // Pin: battery supply in range.
  input wire logic vpwr_por,  // Pin: battery below power-on reset level.
  input wire logic device_reset_n,  // Pin: device reset input, active low.
  output olds_pkg::olds_config_type config_q,  // Held configuration.
  output logic [3:0] switch_output,  // Gate command per output.
  output logic [3:0] on_openload_flag,  // Latched on-state open-load.
  output logic temp_prewarning_flag,  // Latched temperature prewarning.
  output logic undervoltage_flag,  // Latched battery undervoltage.
  output logic fault_status_n,  // Fault status pin, active low.
  output olds_pkg::olds_sense_type sense_route,  // Sense output routing.
  output logic retry_count_reset  // Pulse: clear autoretry counters.
);

  // Refuse a period the timer cannot count or too short to time.
  if (LED_PERIOD < 2 || LED_PERIOD >= (2 ** olds_pkg::TIMER_WIDTH))
  begin : g_bad_period
    $error("LED period does not fit the timer");
  end

  // Period end value at timer width.
  localparam logic [olds_pkg::TIMER_WIDTH-1:0] PERIOD_END =
    olds_pkg::TIMER_WIDTH'(LED_PERIOD - 1);

  // Raw pins gathered for the synchroniser.
  logic [olds_pkg::ASYNC_WIDTH-1:0] async_in;
  // Three-stage synchroniser chain.
  logic [olds_pkg::ASYNC_WIDTH-1:0] sync_1;
  logic [olds_pkg::ASYNC_WIDTH-1:0] sync_2;
  logic [olds_pkg::ASYNC_WIDTH-1:0] sync_3;
  // Filtered levels, updated when stages two and three agree.
  logic [olds_pkg::ASYNC_WIDTH-1:0] pin;

  assign async_in = {device_reset_n, vpwr_por, vpwr_ok, vdd_low, vdd_present, ground_lost,
                     clamp_high, temp_hot, direct_in, overload_off, led_low, bulb_low};

  // Synchroniser stages; stage one feeds stage two only.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync_1 <= olds_pkg::ASYNC_RESET;
      sync_2 <= olds_pkg::ASYNC_RESET;
      sync_3 <= olds_pkg::ASYNC_RESET;
    end
    else
    begin
      sync_1 <= async_in;
      sync_2 <= sync_1;
      sync_3 <= sync_2;
    end
  end

  // Per-bit filter: a change counts once stages two and three agree.
  genvar b;
  generate
    for (b = 0; b < olds_pkg::ASYNC_WIDTH; b++)
    begin : g_filter
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
          pin[b] <= olds_pkg::ASYNC_RESET[b];
        else if (sync_2[b] == sync_3[b])
          pin[b] <= sync_2[b];
      end
    end
  endgenerate

  // Filtered pin levels by name.
  logic [3:0] s_bulb_low;
  logic [3:0] s_led_low;
  logic [3:0] s_overload;
  logic [3:0] s_direct;
  logic s_temp_hot;
  logic s_clamp;
  logic s_gnd_lost;
  logic s_vdd_present;
  logic s_vdd_low;
  logic s_vpwr_ok;
  logic s_vpwr_por;
  logic s_reset_pin_n;

  assign s_bulb_low = pin[olds_pkg::POS_BULB_LOW +: 4];
  assign s_led_low = pin[olds_pkg::POS_LED_LOW +: 4];
  assign s_overload = pin[olds_pkg::POS_OVERLOAD +: 4];
  assign s_direct = pin[olds_pkg::POS_DIRECT +: 4];
  assign s_temp_hot = pin[olds_pkg::POS_TEMP_HOT];
  assign s_clamp = pin[olds_pkg::POS_CLAMP];
  assign s_gnd_lost = pin[olds_pkg::POS_GND_LOST];
  assign s_vdd_present = pin[olds_pkg::POS_VDD_PRESENT];
  assign s_vdd_low = pin[olds_pkg::POS_VDD_LOW];
  assign s_vpwr_ok = pin[olds_pkg::POS_VPWR_OK];
  assign s_vpwr_por = pin[olds_pkg::POS_VPWR_POR];
  assign s_reset_pin_n = pin[olds_pkg::POS_RESET_PIN];

  // Logic supply lost: absent, or low with fail detection enabled.
  logic vdd_lost;
  // Both supplies below the power-on reset level.
  logic both_por;
  // Configuration is wiped while any of these holds.
  logic config_clear;
  // Latched faults are wiped while any of these holds.
  logic fault_clear;

  assign vdd_lost = !s_vdd_present || (s_vdd_low && config_q.vdd_fail_enable);
  assign both_por = s_vpwr_por && !s_vdd_present;
  // Battery loss alone is absent here, so configuration survives it.
  assign config_clear = vdd_lost || both_por || !s_reset_pin_n;
  assign fault_clear = vdd_lost || both_por;

  // Configuration store; cleared contents are the all-zero defaults.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      config_q <= olds_pkg::CONFIG_RESET;
    else if (config_clear)
      config_q <= olds_pkg::CONFIG_RESET;
    else if (config_write)
      config_q <= config_data;
  end

  // Output command before protection overrides.
  logic [3:0] commanded;
  // Output state after protection overrides.
  logic [3:0] next_switch;

  // Without the logic supply only the direct inputs count.
  assign commanded = vdd_lost ? s_direct : (s_direct | config_q.output_on);

  // Override order: ground loss, battery reset, clamp, then overload turn-off.
  always_comb
  begin
    if (s_gnd_lost)
      next_switch = 4'h0;
    else if (s_vpwr_por)
      next_switch = 4'h0;
    else if (s_clamp && (|(commanded & s_overload)))
      next_switch = 4'hf;
    else
      next_switch = commanded & ~s_overload;
  end

  // Registered gate command.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      switch_output <= 4'h0;
    else
      switch_output <= next_switch;
  end

  // Battery reset seen last cycle, for the retry counter pulse.
  logic por_seen;

  // One pulse clears the autoretry counters when a battery reset begins.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      por_seen <= 1'b0;
      retry_count_reset <= 1'b0;
    end
    else
    begin
      por_seen <= s_vpwr_por;
      retry_count_reset <= s_vpwr_por && !por_seen;
    end
  end

  // Per-output LED period tick and open-load set and clear terms.
  logic [3:0] led_tick;
  logic [3:0] ol_set;
  logic [3:0] ol_present;

  genvar i;
  generate
    for (i = 0; i < olds_pkg::OUTPUTS; i++)
    begin : g_output
      // Time the output has been fully on in LED mode.
      logic [olds_pkg::TIMER_WIDTH-1:0] timer;
      // Output runs fully on with the LED threshold chosen.
      logic led_full;

      assign led_full = switch_output[i] && config_q.led_load_select[i] &&
                        (config_q.duty_code[i*8 +: 8] == olds_pkg::FULL_DUTY);

      // Period timer restarts whenever the output leaves full-on LED operation.
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
          timer <= '0;
        else if (!led_full || timer == PERIOD_END)
          timer <= '0;
        else
          timer <= timer + 1'b1;
      end

      // A whole period has passed in full-on LED operation.
      assign led_tick[i] = led_full && (timer == PERIOD_END);

      // Threshold picked by load type; LED result only on the checked tick.
      always_comb
      begin
        if (config_q.led_load_select[i])
        begin
          ol_set[i] = led_tick[i] && config_q.pwm_enable && s_led_low[i];
          ol_present[i] = switch_output[i] && s_led_low[i];
        end
        else
        begin
          ol_set[i] = switch_output[i] && s_bulb_low[i];
          ol_present[i] = switch_output[i] && s_bulb_low[i];
        end
      end

      // Flag sets while enabled; clears on a read once the fault is gone.
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
          on_openload_flag[i] <= 1'b0;
        else if (fault_clear)
          on_openload_flag[i] <= 1'b0;
        else if (ol_set[i] && !config_q.on_openload_disable[i])
          on_openload_flag[i] <= 1'b1;
        else if (status_read[i] && !ol_present[i])
          on_openload_flag[i] <= 1'b0;
      end
    end
  endgenerate

  // Prewarning flag: set in normal mode only, cleared by a diagnostic read.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      temp_prewarning_flag <= 1'b0;
    else if (fault_clear)
      temp_prewarning_flag <= 1'b0;
    else if (s_temp_hot && !fail_safe_mode)
      temp_prewarning_flag <= 1'b1;
    else if (diag_read)
      temp_prewarning_flag <= 1'b0;
  end

  // Undervoltage flag reports battery loss; any status read clears it once gone.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      undervoltage_flag <= 1'b0;
    else if (fault_clear)
      undervoltage_flag <= 1'b0;
    else if (!s_vpwr_ok)
      undervoltage_flag <= 1'b1;
    else if (|status_read)
      undervoltage_flag <= 1'b0;
  end

  // Fault pin follows battery loss only; open-load never pulls it low.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      fault_status_n <= 1'b1;
    else
      fault_status_n <= s_vpwr_ok;
  end

  // Sense routing; temperature wins over current when both are enabled.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sense_route <= '0;
    else
    begin
      sense_route.channel <= config_q.sense_output_select;
      sense_route.high_ratio <= config_q.sense_ratio_select[config_q.sense_output_select];
      sense_route.temp_route <= config_q.temp_feedback_enable;
      sense_route.current_route <= config_q.current_sense_enable &&
                                   !config_q.temp_feedback_enable && !fail_safe_mode &&
                                   next_switch[config_q.sense_output_select];
    end
  end

  // Assertions share the device clock and its reset.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_bulb_flag_set: assert property (
    (!fault_clear && !config_q.led_load_select[0] && !config_q.on_openload_disable[0] &&
     switch_output[0] && s_bulb_low[0]) |=> on_openload_flag[0])
    else $error("bulb open-load did not set the flag");
  a_openload_keeps_on: assert property (
    ($rose(on_openload_flag[0]) && !s_gnd_lost && !s_vpwr_por && !s_overload[0])
    |-> $past(next_switch[0]) && fault_status_n == s_vpwr_ok)
    else $error("open-load flag disturbed output or fault pin");
  a_led_needs_pwm: assert property (
    (config_q.led_load_select[2] && !config_q.pwm_enable && !fault_clear &&
     !on_openload_flag[2] && !config_write) |=> !on_openload_flag[2])
    else $error("LED open-load set without PWM enable");
  a_disable_blocks: assert property (
    (config_q.on_openload_disable[1] && !on_openload_flag[1] && !config_write)
    |=> !on_openload_flag[1])
    else $error("disabled output raised open-load");
  a_flag_holds: assert property (
    (on_openload_flag[0] && !status_read[0] && !fault_clear) |=> on_openload_flag[0])
    else $error("open-load flag dropped without read");
  a_ground_off: assert property (
    s_gnd_lost |=> switch_output == 4'h0)
    else $error("output on during ground loss");
  a_clamp_all_on: assert property (
    (!s_gnd_lost && !s_vpwr_por && s_clamp && |(commanded & s_overload))
    |=> switch_output == 4'hf)
    else $error("clamp did not switch all outputs on");
  a_fail_safe_sense: assert property (
    fail_safe_mode |=> !sense_route.current_route)
    else $error("current recopy active in fail-safe");
  a_sense_on_time: assert property (
    sense_route.current_route |-> switch_output[sense_route.channel])
    else $error("current recopy while switch off");
  a_vdd_loss_clear: assert property (
    vdd_lost |=> config_q == olds_pkg::CONFIG_RESET)
    else $error("configuration kept after logic supply loss");
  a_direct_drive: assert property (
    (vdd_lost && !s_gnd_lost && !s_vpwr_por && s_overload == 4'h0)
    |=> switch_output == $past(s_direct))
    else $error("direct inputs lost control");
  a_por_restart: assert property (
    $rose(s_vpwr_por) |=> retry_count_reset && switch_output == 4'h0)
    else $error("battery reset handling wrong");
  a_vpwr_keep: assert property (
    (!s_vpwr_ok && !config_clear && !config_write) |=> $stable(config_q))
    else $error("configuration lost on battery loss");
  a_uv_report: assert property (
    (!s_vpwr_ok && !fault_clear) |=> undervoltage_flag ##1
    (undervoltage_flag || $past(fault_clear || |status_read)))
    else $error("battery loss not reported");
  a_both_clear: assert property (
    both_por |=> on_openload_flag == 4'h0 && !temp_prewarning_flag && !undervoltage_flag)
    else $error("latched faults survived both-supply loss");
  a_prewarn_latch: assert property (
    (temp_prewarning_flag && !diag_read && !fault_clear) |=> temp_prewarning_flag)
    else $error("prewarning dropped without read");

  c_led_check: cover property (led_tick[0] && config_q.pwm_enable && s_led_low[0]);
  c_flag_read: cover property (on_openload_flag[0] ##1 status_read[0] ##1 !on_openload_flag[0]);
  c_clamp: cover property (s_clamp && |s_overload ##1 switch_output == 4'hf);
  c_vpwr_loss: cover property (!s_vpwr_ok ##1 undervoltage_flag && config_q != '0);

endmodule

// File: bench/olds_host.sv
// Far-side model that drives the analog and supply pins of the block.
`timescale 1ns/1ns
module olds_host (
  input wire logic clk,  // Device clock.
  output logic [3:0] bulb_low,  // Current below bulb threshold.
  output logic [3:0] led_low,  // Current below LED threshold.
  output logic [3:0] overload_off,  // Overload turn-off running.
  output logic [3:0] direct_in,  // Direct inputs.
  output logic temp_hot,  // Ground flag above prewarning.
  output logic clamp_high,  // Supply above clamp.
  output logic ground_lost,  // Ground disconnected.
  output logic vdd_present,  // Logic supply present.
  output logic vdd_low,  // Logic supply below fail level.
  output logic vpwr_ok,  // Battery in range.
  output logic vpwr_por,  // Battery below reset level.
  output logic device_reset_n  // Reset pin, active low.
);
  // Pin levels in the order of the package positions.
  logic [23:0] pins = olds_pkg::ASYNC_RESET;
  assign {device_reset_n, vpwr_por, vpwr_ok, vdd_low, vdd_present} = pins[23:19];
  assign {ground_lost, clamp_high, temp_hot} = pins[18:16];
  assign {direct_in, overload_off, led_low, bulb_low} = pins[15:0];
  // Changes masked pins just after a rising edge.
  task automatic put(input logic [23:0] m, input logic [23:0] v);
    logic [23:0] n;
    @(posedge clk);
    n = (pins & ~m) | (v & m);
    // A host drops its direct commands while the battery is in reset range.
    if (n[olds_pkg::POS_VPWR_POR] === 1'b1)
    begin
      n[15:12] = 4'h0;
    end
    pins <= n;
  endtask
endmodule

// File: bench/olds_core_tb.sv
// Self-checking testbench of the open-load and supply-loss block.
`timescale 1ns/1ns
module olds_core_tb;
  logic clk = 1'b0;  // Clock.
  logic reset_n = 1'b0;  // Reset.
  logic config_write = 1'b0;  // Config strobe.
  olds_pkg::olds_config_type config_data = '0;  // Config word.
  olds_pkg::olds_config_type c;  // Working config.
  logic [3:0] status_read = 4'h0;  // Status read strobes.
  logic diag_read = 1'b0;  // Diagnostic read strobe.
  logic fail_safe_mode = 1'b0;  // Fail-safe level.
  logic [3:0] bulb_low, led_low, overload_off, direct_in;  // Pins from the model.
  logic temp_hot, clamp_high, ground_lost, vdd_present, vdd_low;  // Pins.
  logic vpwr_ok, vpwr_por, device_reset_n;  // Supply pins.
  olds_pkg::olds_config_type config_q;  // Held config.
  logic [3:0] switch_output, on_openload_flag;  // Gates and flags.
  logic temp_prewarning_flag, undervoltage_flag, fault_status_n;  // Status.
  olds_pkg::olds_sense_type sense_route;  // Sense routing.
  logic retry_count_reset;  // Retry clear pulse.
  logic retry_seen = 1'b0;  // Sticky copy of the retry pulse.
  int errors = 0;  // Mismatches.
  int checks = 0;  // Comparisons.
  // Clock of 4 ns period.
  always #2 clk = ~clk;
  // Catches the one-cycle retry clear pulse.
  always @(posedge clk)
  begin
    if (retry_count_reset === 1'b1)
    begin
      retry_seen <= 1'b1;
    end
  end
  olds_host olds_host_i (.clk(clk), .bulb_low(bulb_low), .led_low(led_low),
    .overload_off(overload_off), .direct_in(direct_in), .temp_hot(temp_hot),
    .clamp_high(clamp_high), .ground_lost(ground_lost), .vdd_present(vdd_present),
    .vdd_low(vdd_low), .vpwr_ok(vpwr_ok), .vpwr_por(vpwr_por),
    .device_reset_n(device_reset_n));
  olds_core #(.LED_PERIOD(8)) olds_core_i (.clk(clk), .reset_n(reset_n),
    .config_write(config_write), .config_data(config_data), .status_read(status_read),
    .diag_read(diag_read), .fail_safe_mode(fail_safe_mode), .bulb_low(bulb_low),
    .led_low(led_low), .overload_off(overload_off), .direct_in(direct_in),
    .temp_hot(temp_hot), .clamp_high(clamp_high), .ground_lost(ground_lost),
    .vdd_present(vdd_present), .vdd_low(vdd_low), .vpwr_ok(vpwr_ok),
    .vpwr_por(vpwr_por), .device_reset_n(device_reset_n), .config_q(config_q),
    .switch_output(switch_output), .on_openload_flag(on_openload_flag),
    .temp_prewarning_flag(temp_prewarning_flag), .undervoltage_flag(undervoltage_flag),
    .fault_status_n(fault_status_n), .sense_route(sense_route),
    .retry_count_reset(retry_count_reset));
  // Compares one value and counts it.
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Waits a number of rising edges.
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Sets a group of pins and lets them pass the synchroniser.
  task automatic pin(input int p, input int w, input logic [3:0] v);
    olds_host_i.put(24'((32'h1 << w) - 1) << p, 24'(v) << p);
    wt(8);
  endtask
  // Writes a configuration word with a one-cycle strobe.
  task automatic cfg(input olds_pkg::olds_config_type d);
    @(posedge clk);
    config_data <= d;
    config_write <= 1'b1;
    @(posedge clk);
    config_write <= 1'b0;
    wt(3);
  endtask
  // Issues read strobes for one cycle.
  task automatic rd(input logic [3:0] s, input logic d);
    @(posedge clk);
    status_read <= s;
    diag_read <= d;
    @(posedge clk);
    status_read <= 4'h0;
    diag_read <= 1'b0;
    wt(2);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Cuts a hang short.
  initial
  begin
    #40000;
    errors++;
    final_report();
  end
  // Main test sequence.
  initial
  begin
    wt(4);
    reset_n <= 1'b1;
    wt(1);
    chk("reset", {switch_output, on_openload_flag, fault_status_n}, 9'h001);
    chk("reset_cfg", config_q, '0);
    $display("test reset done");
    c = '0;
    c.output_on = 4'h3;
    c.on_openload_disable = 4'h2;
    cfg(c);
    pin(olds_pkg::POS_BULB_LOW, 4, 4'h3);
    chk("bulb_flag", on_openload_flag, 4'h1);
    chk("bulb_on", {switch_output, fault_status_n}, 5'h07);
    rd(4'h1, 1'b0);
    chk("flag_held", on_openload_flag, 4'h1);
    pin(olds_pkg::POS_BULB_LOW, 4, 4'h0);
    chk("flag_noread", on_openload_flag, 4'h1);
    rd(4'h1, 1'b0);
    chk("flag_clr", on_openload_flag, 4'h0);
    $display("test bulb done");
    c = '0;
    c.output_on = 4'h4;
    c.led_load_select = 4'h4;
    c.duty_code = 32'h00ff0000;
    cfg(c);
    pin(olds_pkg::POS_BULB_LOW, 4, 4'h4);
    pin(olds_pkg::POS_LED_LOW, 4, 4'h4);
    wt(20);
    chk("led_nopwm", on_openload_flag, 4'h0);
    c.pwm_enable = 1'b1;
    cfg(c);
    wt(20);
    chk("led_flag", on_openload_flag, 4'h4);
    pin(olds_pkg::POS_LED_LOW, 4, 4'h0);
    pin(olds_pkg::POS_BULB_LOW, 4, 4'h0);
    rd(4'h4, 1'b0);
    chk("led_clr", on_openload_flag, 4'h0);
    $display("test led done");
    c = '0;
    c.output_on = 4'h1;
    c.current_sense_enable = 1'b1;
    c.sense_ratio_select = 4'h1;
    cfg(c);
    chk("sense_on", sense_route, 5'h09);
    fail_safe_mode <= 1'b1;
    wt(3);
    chk("sense_fs", sense_route.current_route, 1'b0);
    fail_safe_mode <= 1'b0;
    c.output_on = 4'h0;
    cfg(c);
    chk("sense_off", sense_route.current_route, 1'b0);
    c.temp_feedback_enable = 1'b1;
    cfg(c);
    chk("sense_temp", sense_route.temp_route, 1'b1);
    c = '0;
    c.output_on = 4'h4;
    c.current_sense_enable = 1'b1;
    c.sense_output_select = 2'h2;
    c.sense_ratio_select = 4'h4;
    cfg(c);
    chk("sense_sel", sense_route, 5'h0d);
    $display("test sense done");
    pin(olds_pkg::POS_TEMP_HOT, 1, 4'h1);
    rd(4'h0, 1'b1);
    chk("warn_held", temp_prewarning_flag, 1'b1);
    pin(olds_pkg::POS_TEMP_HOT, 1, 4'h0);
    rd(4'h0, 1'b1);
    chk("warn_clr", temp_prewarning_flag, 1'b0);
    fail_safe_mode <= 1'b1;
    pin(olds_pkg::POS_TEMP_HOT, 1, 4'h1);
    chk("warn_fs", temp_prewarning_flag, 1'b0);
    pin(olds_pkg::POS_TEMP_HOT, 1, 4'h0);
    fail_safe_mode <= 1'b0;
    $display("test prewarning done");
    c = '0;
    c.output_on = 4'h1;
    cfg(c);
    pin(olds_pkg::POS_OVERLOAD, 4, 4'h1);
    pin(olds_pkg::POS_CLAMP, 1, 4'h1);
    chk("clamp", switch_output, 4'hf);
    pin(olds_pkg::POS_GND_LOST, 1, 4'h1);
    chk("gnd", switch_output, 4'h0);
    pin(olds_pkg::POS_GND_LOST, 1, 4'h0);
    pin(olds_pkg::POS_CLAMP, 1, 4'h0);
    pin(olds_pkg::POS_OVERLOAD, 4, 4'h0);
    $display("test clamp done");
    pin(olds_pkg::POS_VDD_PRESENT, 1, 4'h0);
    pin(olds_pkg::POS_DIRECT, 4, 4'h8);
    chk("vdd_cfg", config_q, '0);
    chk("vdd_direct", switch_output, 4'h8);
    cfg(c);
    chk("vdd_refuse", config_q, '0);
    pin(olds_pkg::POS_VDD_PRESENT, 1, 4'h1);
    pin(olds_pkg::POS_DIRECT, 4, 4'h0);
    c.vdd_fail_enable = 1'b1;
    cfg(c);
    pin(olds_pkg::POS_VDD_LOW, 1, 4'h1);
    chk("vdd_low", config_q, '0);
    pin(olds_pkg::POS_VDD_LOW, 1, 4'h0);
    $display("test logic supply done");
    c.vdd_fail_enable = 1'b0;
    cfg(c);
    pin(olds_pkg::POS_VPWR_OK, 1, 4'h0);
    chk("uv", {undervoltage_flag, fault_status_n}, 2'h2);
    chk("uv_keep", config_q, c);
    c.output_on = 4'h2;
    cfg(c);
    chk("uv_write", config_q, c);
    pin(olds_pkg::POS_VPWR_OK, 1, 4'h1);
    rd(4'h1, 1'b0);
    chk("uv_clr", undervoltage_flag, 1'b0);
    pin(olds_pkg::POS_RESET_PIN, 1, 4'h0);
    chk("rst_pin", config_q, '0);
    pin(olds_pkg::POS_RESET_PIN, 1, 4'h1);
    $display("test battery done");
    c.output_on = 4'h1;
    cfg(c);
    retry_seen <= 1'b0;
    pin(olds_pkg::POS_VPWR_POR, 1, 4'h1);
    chk("por_off", {switch_output, retry_seen}, 5'h01);
    pin(olds_pkg::POS_VPWR_POR, 1, 4'h0);
    chk("por_back", switch_output, 4'h1);
    pin(olds_pkg::POS_VPWR_OK, 1, 4'h0);
    pin(olds_pkg::POS_VPWR_POR, 1, 4'h1);
    pin(olds_pkg::POS_VDD_PRESENT, 1, 4'h0);
    chk("both", {config_q, undervoltage_flag}, 57'h0);
    $display("test power-on reset done");
    final_report();
  end
endmodule
